// >>> design/scis_irq_status.sv
// interrupt event flags, mask and pll/carrier tracking of one serial channel
`timescale 1ns/100ps
`default_nettype none
`include "scis_consts.svh"
module scis_irq_status
  import scis_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // register bus
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // receiver and line side
  input  wire logic              rx_char_valid,
  input  wire logic              rx_parity_bad,
  input  wire logic              rx_stop_bit,
  input  wire logic              rx_fifo_write,
  input  wire logic              rx_fifo_full,
  input  wire logic              dpll_locked,
  input  wire logic              carrier_sense_line,
  // outputs to the channel and the host
  output var  logic              interrupt_request_line,
  output var  logic              rx_enable,
  output var  logic              tx_enable,
  output var  logic              rx_status_valid,
  output var  logic [7:0]        rx_status_byte
);

  // register strobes from the bus front end
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  // software visible state
  logic [31:0] interrupt_event_flags;
  logic [31:0] event_mask;
  logic [31:0] channel_config_0;
  logic [31:0] channel_config_2;
  logic [31:0] next_flags;
  logic [31:0] next_mask;
  logic [31:0] next_cfg0;
  logic [31:0] next_cfg2;
  logic [31:0] flag_clear;
  logic [31:0] flag_set;
  logic [31:0] visible_flags;

  // channel decode
  scis_mode_t      chan_mode;
  scis_coding_t    line_coding;
  logic            char_mode;
  logic            hdlc_mode;
  logic            pll_applies;
  logic            parity_check_enable;
  logic            rx_status_byte_enable;
  logic            masked_flag_visibility;

  // line tracking
  scis_pll_state_t pll_state;
  scis_pll_state_t next_pll_state;
  logic            dpll_locked_q;
  logic            pll_loss_event;
  logic            carrier_q;
  logic            carrier_primed;
  logic            carrier_event;

  // expands byte strobes into a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : strb_bits

  // merges a strobed write into the writable bits of a register
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  s,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = strb_bits(s) & wmask;
    return (old_val & ~m) | (new_val & m);
  endfunction : merge_write

  // address match against a byte offset
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction : at

  // any mapped register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return at(a, `SCIS_OFS_FLAGS) | at(a, `SCIS_OFS_CLEAR) | at(a, `SCIS_OFS_MASK) |
           at(a, `SCIS_OFS_CFG0) | at(a, `SCIS_OFS_CFG2) | at(a, `SCIS_OFS_LINE);
  endfunction : is_mapped

  scis_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // configuration fields
  always_comb begin
    chan_mode              = scis_mode_t'(channel_config_0[`SCIS_CFG0_MODE_HI:0]);
    line_coding            = scis_coding_t'(channel_config_0[`SCIS_CFG0_CODE_HI:`SCIS_CFG0_CODE_LO]);
    char_mode              = (chan_mode == SCIS_MODE_ASYNC) | (chan_mode == SCIS_MODE_ISOCHR);
    hdlc_mode              = chan_mode == SCIS_MODE_HDLC;
    parity_check_enable    = channel_config_2[`SCIS_CFG2_PAR_EN];
    rx_status_byte_enable  = channel_config_2[`SCIS_CFG2_SB_EN];
    masked_flag_visibility = channel_config_0[`SCIS_CFG0_VIS];
    // lock loss only matters for self clocking codes
    pll_applies = channel_config_0[`SCIS_CFG0_RXDPLL] &
                  ((line_coding == SCIS_CODE_FM0) | (line_coding == SCIS_CODE_FM1) |
                   (line_coding == SCIS_CODE_MANCH)); // RULE_04
  end

  // edges of the lock and carrier levels
  always_comb begin
    pll_loss_event = pll_applies & dpll_locked_q & ~dpll_locked; // RULE_04
    carrier_event  = carrier_primed & (carrier_sense_line != carrier_q); // RULE_07
  end

  // previous samples; carrier compare waits for one real sample
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dpll_locked_q  <= 1'b0;
      carrier_q      <= 1'b0;
      carrier_primed <= 1'b0;
    end else begin
      dpll_locked_q  <= dpll_locked;
      carrier_q      <= carrier_sense_line;
      carrier_primed <= 1'b1;
    end
  end

  // pll sync tracking: lost until the pll reports lock again or pll_applies drops
  always_comb begin
    case (pll_state)
      SCIS_PLL_SYNC: begin
        next_pll_state = pll_loss_event ? SCIS_PLL_LOST : SCIS_PLL_SYNC;
      end
      SCIS_PLL_LOST: begin
        // leaving a pll coding also releases the hold
        next_pll_state = (dpll_locked | ~pll_applies) ? SCIS_PLL_SYNC : SCIS_PLL_LOST; // RULE_05
      end
      default: begin
        next_pll_state = SCIS_PLL_SYNC;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_state <= SCIS_PLL_SYNC;
    end else begin
      pll_state <= next_pll_state;
    end
  end

  // receive and transmit gates follow the next pll state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_enable <= 1'b1;
      tx_enable <= 1'b1;
    end else begin
      rx_enable <= next_pll_state == SCIS_PLL_SYNC; // RULE_05
      tx_enable <= ~((next_pll_state == SCIS_PLL_LOST) &
                     channel_config_0[`SCIS_CFG0_TXDPLL]); // RULE_06
    end
  end

  // events of this cycle; receive events count only while rx runs
  always_comb begin
    flag_set = 32'h00000000;
    flag_set[`SCIS_BIT_PARITY] = char_mode & parity_check_enable & rx_enable &
                                 rx_char_valid & rx_parity_bad; // RULE_01
    flag_set[`SCIS_BIT_FRAMING] = char_mode & rx_enable & rx_char_valid &
                                  ~rx_stop_bit; // RULE_03
    flag_set[`SCIS_BIT_PLL]      = pll_loss_event; // RULE_04
    flag_set[`SCIS_BIT_CARRIER]  = carrier_event; // RULE_07
    flag_set[`SCIS_BIT_OVERFLOW] = rx_enable & rx_fifo_write & rx_fifo_full; // RULE_08
  end

  // write one to clear, through the flags word or its clear alias
  always_comb begin
    flag_clear = 32'h00000000;
    if (wr_en & (at(wr_addr, `SCIS_OFS_FLAGS) | at(wr_addr, `SCIS_OFS_CLEAR))) begin
      flag_clear = wr_data & strb_bits(wr_strb); // RULE_11
    end
    // a new event beats a clear in the same cycle
    next_flags = ((interrupt_event_flags & ~flag_clear) | flag_set) & `SCIS_EVT_MASK; // RULE_11
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_event_flags <= `SCIS_FLAGS_RST;
    end else begin
      interrupt_event_flags <= next_flags;
    end
  end

  // writable control registers
  always_comb begin
    next_mask = event_mask;
    next_cfg0 = channel_config_0;
    next_cfg2 = channel_config_2;
    if (wr_en & at(wr_addr, `SCIS_OFS_MASK)) begin
      next_mask = merge_write(event_mask, wr_data, wr_strb, `SCIS_EVT_MASK);
    end
    if (wr_en & at(wr_addr, `SCIS_OFS_CFG0)) begin
      next_cfg0 = merge_write(channel_config_0, wr_data, wr_strb, `SCIS_CFG0_WMASK);
    end
    if (wr_en & at(wr_addr, `SCIS_OFS_CFG2)) begin
      next_cfg2 = merge_write(channel_config_2, wr_data, wr_strb, `SCIS_CFG2_WMASK);
    end
  end

  // all events start masked so unconnected lines stay quiet
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      event_mask       <= `SCIS_MASK_RST;
      channel_config_0 <= `SCIS_CFG0_RST;
      channel_config_2 <= `SCIS_CFG2_RST;
    end else begin
      event_mask       <= next_mask;
      channel_config_0 <= next_cfg0;
      channel_config_2 <= next_cfg2;
    end
  end

  // interrupt line from unmasked flags, using next values to save a cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_request_line <= 1'b0;
    end else begin
      interrupt_request_line <= |(next_flags & ~next_mask & `SCIS_EVT_MASK); // RULE_12
    end
  end

  // read view of the flags; hidden flags are still tracked
  always_comb begin
    visible_flags = interrupt_event_flags & `SCIS_EVT_MASK; // RULE_09
    if (!masked_flag_visibility) begin // RULE_10
      visible_flags = visible_flags & ~event_mask; // RULE_13
    end
    if (hdlc_mode) begin
      visible_flags = visible_flags & ~`SCIS_HDLC_HIDE; // RULE_09
    end
  end

  // read mux; unmapped addresses give an error and zero data
  always_comb begin
    rd_err  = ~is_mapped(rd_addr);
    wr_err  = ~is_mapped(wr_addr);
    rd_data = 32'h00000000;
    if (at(rd_addr, `SCIS_OFS_FLAGS)) begin
      rd_data = visible_flags;
    end else if (at(rd_addr, `SCIS_OFS_MASK)) begin
      rd_data = event_mask;
    end else if (at(rd_addr, `SCIS_OFS_CFG0)) begin
      rd_data = channel_config_0;
    end else if (at(rd_addr, `SCIS_OFS_CFG2)) begin
      rd_data = channel_config_2;
    end else if (at(rd_addr, `SCIS_OFS_LINE)) begin
      rd_data[`SCIS_LINE_CARRIER] = carrier_sense_line;
      rd_data[`SCIS_LINE_LOCKED]  = dpll_locked;
      rd_data[`SCIS_LINE_LOST]    = pll_state == SCIS_PLL_LOST;
      rd_data[`SCIS_LINE_RXEN]    = rx_enable;
    end
  end

  // per character status byte, one cycle behind the character strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_status_valid <= 1'b0;
      rx_status_byte  <= 8'h00;
    end else begin
      rx_status_valid <= rx_char_valid & rx_enable & rx_status_byte_enable; // RULE_02
      if (rx_char_valid & rx_enable & rx_status_byte_enable) begin
        rx_status_byte <= 8'h00;
        rx_status_byte[`SCIS_SB_PARITY]  <= char_mode & parity_check_enable &
                                            rx_parity_bad; // RULE_02
        rx_status_byte[`SCIS_SB_FRAMING] <= char_mode & ~rx_stop_bit;
      end
    end
  end

endmodule : scis_irq_status
`default_nettype wire

// >>> design/scis_consts.svh
// register map, field positions and reset values of the channel interrupt status block
// Operation
// RULE_01 - async or isochronous: received character with bad parity sets flag bit 5
// RULE_02 - with status byte option on, each character's status byte carries parity error
// RULE_03 - async or isochronous: zero sampled at stop bit position sets flag bit 4
// RULE_04 - pll lock loss sets flag bit 3 when rx clock from pll with fm/manchester
// RULE_05 - after pll lock loss reception stays suspended until lock returns
// RULE_06 - transmit clock from pll: transmission also halted while lock is lost
// RULE_07 - any carrier sense transition sets flag bit 2; level shown elsewhere
// RULE_08 - data dropped because receive fifo is full sets flag bit 1
// RULE_09 - bit 0 always reads zero; bits 9:4 read zero in hdlc mode
// RULE_10 - visibility control one shows flags of masked events in the flags register
// RULE_11 - writing one to a flag bit clears it; zero leaves it unchanged
// RULE_12 - mask bit one keeps the event off the interrupt line; zero drives it
// RULE_13 - visibility zero reads masked flags as zero while still tracking them
`ifndef SCIS_CONSTS_SVH
`define SCIS_CONSTS_SVH

// byte offsets of the registers
`define SCIS_OFS_FLAGS      8'h00
`define SCIS_OFS_CLEAR      8'h04
`define SCIS_OFS_MASK       8'h08
`define SCIS_OFS_CFG0       8'h0C
`define SCIS_OFS_CFG2       8'h10
`define SCIS_OFS_LINE       8'h14

// flag bit positions
`define SCIS_BIT_PARITY     5
`define SCIS_BIT_FRAMING    4
`define SCIS_BIT_PLL        3
`define SCIS_BIT_CARRIER    2
`define SCIS_BIT_OVERFLOW   1
`define SCIS_EVT_MASK       32'h0000003E
`define SCIS_HDLC_HIDE      32'h000003F0

// reset values and writable bits
`define SCIS_FLAGS_RST      32'h00000000
`define SCIS_MASK_RST       32'h0000003E
`define SCIS_CFG0_RST       32'h00000000
`define SCIS_CFG2_RST       32'h00000000
`define SCIS_CFG0_WMASK     32'h000000FF
`define SCIS_CFG2_WMASK     32'h00000003

// channel_config_0 fields
`define SCIS_CFG0_MODE_HI   1
`define SCIS_CFG0_RXDPLL    2
`define SCIS_CFG0_TXDPLL    3
`define SCIS_CFG0_CODE_HI   6
`define SCIS_CFG0_CODE_LO   4
`define SCIS_CFG0_VIS       7

// channel_config_2 fields
`define SCIS_CFG2_PAR_EN    0
`define SCIS_CFG2_SB_EN     1

// line status and receive status byte fields
`define SCIS_LINE_CARRIER   0
`define SCIS_LINE_LOCKED    1
`define SCIS_LINE_LOST      2
`define SCIS_LINE_RXEN      3
`define SCIS_SB_FRAMING     0
`define SCIS_SB_PARITY      1

// bus responses
`define SCIS_RESP_OKAY      2'h0
`define SCIS_RESP_SLVERR    2'h2

`endif

// >>> design/scis_pkg.sv
// types shared by the serial channel interrupt status block
package scis_pkg;

  // channel operating mode
  typedef enum logic [1:0] {
    SCIS_MODE_HDLC   = 2'h0,
    SCIS_MODE_ASYNC  = 2'h1,
    SCIS_MODE_ISOCHR = 2'h2,
    SCIS_MODE_RSVD   = 2'h3
  } scis_mode_t;

  // line coding
  typedef enum logic [2:0] {
    SCIS_CODE_NRZ   = 3'h0,
    SCIS_CODE_NRZI  = 3'h1,
    SCIS_CODE_FM0   = 3'h2,
    SCIS_CODE_FM1   = 3'h3,
    SCIS_CODE_MANCH = 3'h4
  } scis_coding_t;

  // pll synchronisation tracking
  typedef enum logic [1:0] {
    SCIS_PLL_SYNC = 2'b01,
    SCIS_PLL_LOST = 2'b10
  } scis_pll_state_t;

endpackage : scis_pkg

// >>> design/scis_axil_slave.sv
// axi4-lite slave front end turning bus traffic into register strobes
`timescale 1ns/100ps
`default_nettype none
`include "scis_consts.svh"
module scis_axil_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic              wr_en,
  output var  logic [ADDR_W-1:0] wr_addr,
  output var  logic [31:0]       wr_data,
  output var  logic [3:0]        wr_strb,
  input  wire logic              wr_err,
  output var  logic              rd_en,
  output var  logic [ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;

  // write fires once address and data are held and no response waits
  always_comb begin
    wr_en        = aw_held & w_held & ~s_axi_bvalid;
    rd_en        = s_axi_arvalid & s_axi_arready;
    rd_addr      = s_axi_araddr;
    next_aw_held = wr_en ? 1'b0 : (aw_held | (s_axi_awvalid & s_axi_awready));
    next_w_held  = wr_en ? 1'b0 : (w_held | (s_axi_wvalid & s_axi_wready));
    next_bvalid  = wr_en | (s_axi_bvalid & ~s_axi_bready);
    next_rvalid  = rd_en | (s_axi_rvalid & ~s_axi_rready);
  end

  // readies are registered from next state so they never sit on a comb path
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCIS_RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (wr_en) begin
        s_axi_bresp <= wr_err ? `SCIS_RESP_SLVERR : `SCIS_RESP_OKAY;
      end
    end
  end

  // captured write payload
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_addr <= '0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // read channel, data latched on the address handshake
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SCIS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (rd_en) begin
        s_axi_rdata <= rd_err ? 32'h00000000 : rd_data;
        s_axi_rresp <= rd_err ? `SCIS_RESP_SLVERR : `SCIS_RESP_OKAY;
      end
    end
  end
endmodule : scis_axil_slave
`default_nettype wire

// >>> verification/scis_irq_status_monitor.sv
// port checker for the channel interrupt status block
`timescale 1ns/100ps
`default_nettype none
`include "scis_consts.svh"
module scis_irq_status_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              rx_char_valid,
  input wire logic              rx_parity_bad,
  input wire logic              rx_stop_bit,
  input wire logic              rx_fifo_write,
  input wire logic              rx_fifo_full,
  input wire logic              dpll_locked,
  input wire logic              carrier_sense_line,
  input wire logic              interrupt_request_line,
  input wire logic              rx_enable,
  input wire logic              tx_enable,
  input wire logic              rx_status_valid,
  input wire logic [7:0]        rx_status_byte
);
  logic [ADDR_W-1:0] rd_addr_q;

  // address of the read in flight
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end

  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // a write is in its update cycle: aw taken, response not yet up
  sequence wr_update;
    !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  wr_answer_a : assert property (wr_taken |=> wr_update ##1 s_axi_bvalid)
    else $error("late write response");
  pll_drop_a : assert property ($fell(rx_enable) |-> !$past(dpll_locked) && $past(dpll_locked, 2))
    else $error("rx off without lock loss");
  rx_hold_a : assert property (!rx_enable && !dpll_locked && s_axi_awready |=> !rx_enable)
    else $error("rx on while unlocked");
  rx_quiet_a : assert property (!rx_enable |=> !rx_status_valid)
    else $error("status byte while rx off");
  tx_gate_a : assert property (!tx_enable |-> !rx_enable)
    else $error("tx off without lock loss");
  sb_byte_a : assert property (rx_status_valid |-> $past(rx_char_valid)
    && rx_status_byte[7:2] == 6'h00 && rx_status_byte[0] == !$past(rx_stop_bit)
    && (!rx_status_byte[1] || $past(rx_parity_bad)))
    else $error("bad status byte");
  irq_rise_a : assert property ($rose(interrupt_request_line) |->
    $past(rx_fifo_write && rx_fifo_full || rx_char_valid || !s_axi_awready && !s_axi_bvalid)
    || $past(carrier_sense_line) != $past(carrier_sense_line, 2)
    || !$past(dpll_locked) && $past(dpll_locked, 2))
    else $error("irq rose without cause");
  irq_fall_a : assert property ($fell(interrupt_request_line) |-> $past(!s_axi_awready && !s_axi_bvalid))
    else $error("irq fell without write");
  rsvd_read_a : assert property (s_axi_rvalid && rd_addr_q == ADDR_W'(`SCIS_OFS_FLAGS)
    |-> s_axi_rdata[0] == 1'b0 && s_axi_rdata[31:6] == 26'h0)
    else $error("reserved flag bits set");
endmodule : scis_irq_status_monitor

bind scis_irq_status scis_irq_status_monitor #(.ADDR_W(ADDR_W)) u_scis_irq_status_monitor (.*);
`default_nettype wire

// >>> verification/serial_channel_irq_status_test.sv
// self-checking bench for the channel interrupt status block
`timescale 1ns/100ps
`default_nettype none
`include "scis_consts.svh"
module serial_channel_irq_status_test;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        rx_char_valid = 1'b0;
  logic        rx_parity_bad = 1'b0;
  logic        rx_stop_bit = 1'b1;
  logic        rx_fifo_write = 1'b0;
  logic        rx_fifo_full = 1'b0;
  logic        dpll_locked = 1'b1;
  logic        carrier_sense_line = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        interrupt_request_line, rx_enable, tx_enable, rx_status_valid;
  logic [7:0]  rx_status_byte;
  int          err_total = 0;
  int          num_checks = 0;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] bit_v;

  // 100 MHz
  always #5 mclk = ~mclk;

  scis_irq_status #(.ADDR_W(8)) u_scis_irq_status (.*);

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // a stuck handshake ends the run rather than hanging it
  task automatic tmo(input int n);
    if (n >= 50) begin
      chk(1'b0, "handshake timeout");
      wrap_up();
    end
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge mclk);
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge mclk);
    rq.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask : axi_rd

  // one event per call: k is also the flag bit it should set
  task automatic fire(input int k);
    @(posedge mclk);
    rx_char_valid      <= (k >= 4);
    rx_parity_bad      <= (k == 5);
    rx_stop_bit        <= (k != 4);
    rx_fifo_write      <= (k == 1);
    rx_fifo_full       <= (k == 1);
    carrier_sense_line <= carrier_sense_line ^ (k == 2);
    dpll_locked        <= (k != 3);
    @(posedge mclk);
    rx_char_valid <= 1'b0;
    rx_fifo_write <= 1'b0;
    @(posedge mclk);
  endtask : fire

  // oldest expectation against each completed transfer
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata} === rq.pop_front(), "read");
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === bq.pop_front(), "write response");
  end

  initial begin
    bit_v = $urandom(32'hC8407711);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    axi_rd(`SCIS_OFS_FLAGS, `SCIS_FLAGS_RST, `SCIS_RESP_OKAY);
    axi_rd(`SCIS_OFS_MASK, `SCIS_MASK_RST, `SCIS_RESP_OKAY);
    axi_rd(8'h20, 32'h0, `SCIS_RESP_SLVERR);
    axi_wr(8'h20, 32'hFFFFFFFF, `SCIS_RESP_SLVERR);
    chk(interrupt_request_line === 1'b0, "irq after reset");
    $display("test reset done");
    // async, rx and tx clocks from pll, fm0 coding, parity and status byte on
    axi_wr(`SCIS_OFS_CFG0, 32'h0000002D, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_CFG2, 32'h00000003, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_MASK, 32'h0, `SCIS_RESP_OKAY);
    for (int k = 1; k <= 5; k++) begin
      bit_v = 32'h1 << k;
      fire(k);
      chk(interrupt_request_line === 1'b1, "irq not raised");
      if (k == 3) chk({rx_enable, tx_enable} === 2'b00, "pll loss gating");
      if (k >= 4) chk(rx_status_byte === 8'(k - 3), "status byte");
      axi_rd(`SCIS_OFS_FLAGS, bit_v, `SCIS_RESP_OKAY);
      axi_wr(`SCIS_OFS_FLAGS, $urandom & ~bit_v, `SCIS_RESP_OKAY);
      axi_rd(`SCIS_OFS_FLAGS, bit_v, `SCIS_RESP_OKAY);
      dpll_locked <= 1'b1;
      axi_wr(`SCIS_OFS_CLEAR, bit_v, `SCIS_RESP_OKAY);
      axi_rd(`SCIS_OFS_FLAGS, 32'h0, `SCIS_RESP_OKAY);
      chk(interrupt_request_line === 1'b0, "irq not cleared");
      chk(rx_enable === 1'b1, "rx not resumed");
    end
    $display("test events done");
    fire(5);
    axi_wr(`SCIS_OFS_CFG0, 32'h0000002C, `SCIS_RESP_OKAY);
    axi_rd(`SCIS_OFS_FLAGS, 32'h0, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_CFG0, 32'h000000AD, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_MASK, 32'h00000020, `SCIS_RESP_OKAY);
    chk(interrupt_request_line === 1'b0, "masked event drives irq");
    axi_rd(`SCIS_OFS_FLAGS, 32'h00000020, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_CFG0, 32'h0000002D, `SCIS_RESP_OKAY);
    axi_rd(`SCIS_OFS_FLAGS, 32'h0, `SCIS_RESP_OKAY);
    axi_wr(`SCIS_OFS_MASK, 32'h0, `SCIS_RESP_OKAY);
    chk(interrupt_request_line === 1'b1, "hidden flag lost");
    $display("test visibility done");
    wrap_up();
  end
endmodule : serial_channel_irq_status_test
`default_nettype wire
